/* hw/clk_sel_cfg.svh */
// register map, field positions, reset values and counts for clock select
`ifndef CLK_SEL_CFG_SVH
`define CLK_SEL_CFG_SVH

`define DATA_W                16
`define ADDR_W                16
`define WORD_ZERO             16'h0000

`define ADDR_OSC_WAKE_MASK    16'h1c98
`define ADDR_CLOCK_OUT_ROUTE  16'h8400
`define ADDR_CLOCK_INPUT_MODE 16'h8c00
`define ADDR_AUX_CLOCK_ROUTE  16'h1c9c
`define ADDR_PLL_CTRL_STATUS  16'h1c80

`define WAKE_W                5
`define WAKE_MSB              4
`define WAKE_NMI_BIT          0
`define WAKE_IRQ0_BIT         1
`define WAKE_IRQ1_BIT         2
`define WAKE_IRQ2_BIT         3
`define WAKE_IRQ3_BIT         4
`define WAKE_MASK_RESET       5'h1f
`define WAKE_NONE             5'h00

`define AUX_SEL_MSB           3
`define AUX_SEL_RESET         4'hb
`define AUX_SEL_DIRECT        4'hb
`define AUX_SEL_TAP_A         4'ha
`define AUX_SEL_TAP_B         4'h8
`define AUX_SEL_OSC_DIV       4'h9

`define ROUTE_DIS_BIT         0
`define ROUTE_SRC_LSB         1
`define ROUTE_SRC_MSB         2
`define MAIN_SRC_RESET        2'h1
`define MAIN_SRC_RSVD         2'h0
`define MAIN_SRC_SYS1         2'h1
`define MAIN_SRC_SYS2         2'h2
`define MAIN_SRC_SYS3         2'h3
`define MAIN_DIS_RESET        1'b0

`define INPUT_SRC_BIT         0
`define PLLCS_SLEEP_BIT       0
`define PLLCS_BUSY_BIT        1
`define PLLCS_SLEEP_RESET     1'b0

`define STAB_CYCLES_DEFAULT   41032
`define STAB_CNT_W            16
`define STAB_CNT_ZERO         16'h0000

`define ST_AWAKE              2'b00
`define ST_SLEEP              2'b01
`define ST_STABLE             2'b11

`endif

/* hw/clk_sel_pkg.sv */
// shared types for the clock output and wake select block
package clk_sel_pkg;
  `include "clk_sel_cfg.svh"

  typedef logic [`DATA_W-1:0]     reg_word_t;
  typedef logic [`ADDR_W-1:0]     reg_addr_t;
  typedef logic [`WAKE_W-1:0]     wake_vec_t;
  typedef logic [`STAB_CNT_W-1:0] stab_cnt_t;

  typedef enum logic [1:0] {
    ST_AWAKE_E  = `ST_AWAKE,
    ST_SLEEP_E  = `ST_SLEEP,
    ST_STABLE_E = `ST_STABLE
  } wake_state_t;
endpackage

/* hw/wake_if.sv */
// wake request and status signals between register file and wake monitor
`timescale 1ns/1ps
interface wake_if;
  import clk_sel_pkg::*;

  wake_vec_t irq_raw;
  wake_vec_t mask;
  logic      sleep;
  logic      wake;
  logic      stab_busy;
  logic      resume;

  modport ctrl (
    output irq_raw,
    output mask,
    output sleep,
    input  wake,
    input  stab_busy,
    input  resume
  );

  modport mon (
    input  irq_raw,
    input  mask,
    input  sleep,
    output wake,
    output stab_busy,
    output resume
  );
endinterface

/* hw/wake_monitor.sv */
// wake edge detection and oscillator stabilisation counter
`timescale 1ns/1ps
`include "clk_sel_cfg.svh"
module wake_monitor #(
  parameter int STAB_CYCLES = `STAB_CYCLES_DEFAULT
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  wake_if.mon      wk
);
  import clk_sel_pkg::*;

  localparam stab_cnt_t STAB_LOAD = stab_cnt_t'(STAB_CYCLES - 1);

  wake_vec_t   sync1_reg;
  wake_vec_t   sync2_reg;
  wake_vec_t   prev_reg;
  wake_vec_t   rise;
  wake_vec_t   armed;
  wake_state_t state_reg;
  wake_state_t state_next;
  stab_cnt_t   cnt_reg;
  stab_cnt_t   cnt_next;
  logic        cnt_done;

  // three flops per pin; the second and third stages feed edge logic.
  // no reset: the chain tracks the pins through reset, so a pin
  // held high across reset gives no false edge at release
  always_ff @(posedge mclk_in) begin
    sync1_reg <= wk.irq_raw;
    sync2_reg <= sync1_reg;
    prev_reg  <= sync2_reg;
  end

  // reference clock keeps running, so edges are caught synchronously
  assign rise     = sync2_reg & ~prev_reg;
  assign armed    = rise & ~wk.mask;
  assign wk.wake  = (state_reg == ST_SLEEP_E) && wk.sleep
                    && (armed != `WAKE_NONE);
  assign cnt_done = (cnt_reg == `STAB_CNT_ZERO);

  // sleep, then stabilise for the full count before resuming
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_AWAKE_E: begin
        if (wk.sleep) begin
          state_next = ST_SLEEP_E;
        end
      end
      ST_SLEEP_E: begin
        if (wk.wake) begin
          state_next = ST_STABLE_E;
          cnt_next   = STAB_LOAD;
        end else if (!wk.sleep) begin
          state_next = ST_AWAKE_E;
        end
      end
      ST_STABLE_E: begin
        if (cnt_done) begin
          state_next = ST_AWAKE_E;
        end else begin
          cnt_next = cnt_reg - stab_cnt_t'(1);
        end
      end
      default: begin
        state_next = ST_AWAKE_E;
        cnt_next   = `STAB_CNT_ZERO;
      end
    endcase
  end

  // state and counter
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_AWAKE_E;
      cnt_reg   <= `STAB_CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign wk.stab_busy = (state_reg == ST_STABLE_E);
  assign wk.resume    = (state_reg == ST_AWAKE_E) && !wk.sleep;
endmodule

/* hw/clock_out_and_wake_select.sv */
// clock output routing, input clock select and oscillator wake masking
`timescale 1ns/1ps
`include "clk_sel_cfg.svh"
// What this block does
// - mask bits map NMI and external irqs 0-3
// - unmasked rising edge wakes, clears sleep flag
// - masked input edges never wake the oscillator
// - wake detection only while sleep flag set
// - mask resets all ones; upper bits zero
// - aux pin carries direct divided clock normally
// - main source field picks system clock 1-3
// - disable bit forces main clock pin low
// - source bit picks oscillator or external pin
// - source bit reset value from strap pin
// - count stabilisation cycles before resuming program
module clock_out_and_wake_select #(
  parameter int STAB_CYCLES = `STAB_CYCLES_DEFAULT
) (
  // clock, reset and register bus
  input  wire logic                   mclk_in,
  input  wire logic                   sys_rst_in,
  input  wire clk_sel_pkg::reg_addr_t addr_in,
  input  wire clk_sel_pkg::reg_word_t wr_data_in,
  input  wire logic                   wr_en_in,
  input  wire logic                   rd_en_in,
  output      clk_sel_pkg::reg_word_t rd_data_out,
  // wake and strap pins, asynchronous to mclk_in
  input  wire logic                   nmi_in,
  input  wire logic                   ext_irq0_in,
  input  wire logic                   ext_irq1_in,
  input  wire logic                   ext_irq2_in,
  input  wire logic                   ext_irq3_in,
  input  wire logic                   clock_strap_pin_in,
  // clock sources, muxed without sampling
  input  wire logic                   osc_output_in,
  input  wire logic                   ext_clock_pin_in,
  input  wire logic                   sys_clock_1_in,
  input  wire logic                   sys_clock_2_in,
  input  wire logic                   sys_clock_3_in,
  input  wire logic                   pll_tap_a_in,
  input  wire logic                   pll_tap_b_in,
  input  wire logic                   osc_div_clk_in,
  input  wire logic                   direct_div_clk_in,
  // routed clocks and status
  output      logic                   main_clock_pin_out,
  output      logic                   aux_clock_pin_out,
  output      logic                   dev_input_clock_out,
  output      logic                   input_clock_source_bit_out,
  output      logic                   osc_sleep_flag_out,
  output      logic                   stabilizing_out,
  output      logic                   cpu_resume_out
);
  import clk_sel_pkg::*;

  // register state; only implemented bits are stored, reserved
  // bits are rebuilt as zeros on the read path
  wake_vec_t  osc_wake_mask_reg;
  logic [`AUX_SEL_MSB:0] aux_clk_select_reg;
  logic [`ROUTE_SRC_MSB:`ROUTE_SRC_LSB] main_clk_out_source_reg;
  logic       main_clk_out_disable_reg;
  logic       input_clock_source_bit_reg;
  logic       osc_sleep_flag_reg;
  logic       osc_sleep_flag_next;
  reg_word_t  rd_data_reg;
  reg_word_t  rd_data_next;

  // strap synchroniser
  logic       strap_sync1_reg;
  logic       strap_sync2_reg;

  // decode wires
  logic       hit_wake_mask;
  logic       hit_clock_route;
  logic       hit_input_mode;
  logic       hit_aux_route;
  logic       hit_pll_status;
  logic       wr_wake_mask;
  logic       wr_clock_route;
  logic       wr_input_mode;
  logic       wr_aux_route;
  logic       wr_pll_status;

  // named mask bits
  // one wire per input keeps the bit order easy to audit
  logic       wake_mask_nmi;
  logic       wake_mask_irq0;
  logic       wake_mask_irq1;
  logic       wake_mask_irq2;
  logic       wake_mask_irq3;

  // read-back words
  reg_word_t  wake_mask_word;
  reg_word_t  clock_route_word;
  reg_word_t  input_mode_word;
  reg_word_t  aux_route_word;
  reg_word_t  pll_status_word;
  reg_word_t  read_mux;

  // clock selection wires
  // selected clocks; only the main one passes the disable gating
  logic       main_selected_clk;
  logic       aux_selected_clk;

  wake_if wk ();

  // one address compare, reused for every register
  // exact match, so no aliased address can hit a register
  function automatic logic addr_hit(input reg_addr_t a,
                                    input reg_addr_t target);
    addr_hit = (a == target);
  endfunction

  // address decode
  // unmapped addresses match nothing; writes there are lost
  assign hit_wake_mask   = addr_hit(addr_in, `ADDR_OSC_WAKE_MASK);
  assign hit_clock_route = addr_hit(addr_in, `ADDR_CLOCK_OUT_ROUTE);
  assign hit_input_mode  = addr_hit(addr_in, `ADDR_CLOCK_INPUT_MODE);
  assign hit_aux_route   = addr_hit(addr_in, `ADDR_AUX_CLOCK_ROUTE);
  assign hit_pll_status  = addr_hit(addr_in, `ADDR_PLL_CTRL_STATUS);

  // write strobes per register
  assign wr_wake_mask   = wr_en_in && hit_wake_mask;
  assign wr_clock_route = wr_en_in && hit_clock_route;
  assign wr_input_mode  = wr_en_in && hit_input_mode;
  assign wr_aux_route   = wr_en_in && hit_aux_route;
  assign wr_pll_status  = wr_en_in && hit_pll_status;

  // wake mask register; upper bits are not stored at all
  // all ones at reset: nothing wakes until software opts in
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      osc_wake_mask_reg <= `WAKE_MASK_RESET;
    end else if (wr_wake_mask) begin
      osc_wake_mask_reg <= wr_data_in[`WAKE_MSB:0];
    end
  end

  // per-input view of the mask
  assign wake_mask_nmi  = osc_wake_mask_reg[`WAKE_NMI_BIT];
  assign wake_mask_irq0 = osc_wake_mask_reg[`WAKE_IRQ0_BIT];
  assign wake_mask_irq1 = osc_wake_mask_reg[`WAKE_IRQ1_BIT];
  assign wake_mask_irq2 = osc_wake_mask_reg[`WAKE_IRQ2_BIT];
  assign wake_mask_irq3 = osc_wake_mask_reg[`WAKE_IRQ3_BIT];

  // wake inputs in mask bit order; monitor synchronises them
  // raw pins pass through here untouched by any logic
  assign wk.irq_raw = {ext_irq3_in, ext_irq2_in, ext_irq1_in,
                       ext_irq0_in, nmi_in};
  assign wk.mask    = {wake_mask_irq3, wake_mask_irq2, wake_mask_irq1,
                       wake_mask_irq0, wake_mask_nmi};
  assign wk.sleep   = osc_sleep_flag_reg;

  // edge detection, gating and stabilisation count
  // the count is a parameter so simulation can run a short
  // stabilising phase while silicon keeps the full length
  wake_monitor #(
    .STAB_CYCLES (STAB_CYCLES)
  ) u_wake_monitor (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .wk         (wk.mon)
  );

  // sleep flag: software write wins over a wake in the same cycle,
  // since a wake only ever clears and the write states intent
  // limitation: a write of 1 in the wake cycle keeps the flag
  // set although the monitor has already started its count,
  // so software must not rewrite the flag while it is set
  always_comb begin
    osc_sleep_flag_next = osc_sleep_flag_reg;
    if (wr_pll_status) begin
      osc_sleep_flag_next = wr_data_in[`PLLCS_SLEEP_BIT];
    end else if (wk.wake) begin
      osc_sleep_flag_next = 1'b0;
    end
  end

  // sleep flag register; clear at reset so the part runs at once
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      osc_sleep_flag_reg <= `PLLCS_SLEEP_RESET;
    end else begin
      osc_sleep_flag_reg <= osc_sleep_flag_next;
    end
  end

  // aux clock select, reset to the normal direct-divider code
  // any code may be written; the pin only knows four of them
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      aux_clk_select_reg <= `AUX_SEL_RESET;
    end else if (wr_aux_route) begin
      aux_clk_select_reg <= wr_data_in[`AUX_SEL_MSB:0];
    end
  end

  // main clock route: source field and disable bit
  // both fields share one word, so one write updates them together
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      main_clk_out_source_reg  <= `MAIN_SRC_RESET;
      main_clk_out_disable_reg <= `MAIN_DIS_RESET;
    end else if (wr_clock_route) begin
      main_clk_out_source_reg  <=
        wr_data_in[`ROUTE_SRC_MSB:`ROUTE_SRC_LSB];
      main_clk_out_disable_reg <= wr_data_in[`ROUTE_DIS_BIT];
    end
  end

  // strap pin comes from the board, so two flops first
  // no reset: the chain must already carry the strap level
  // by the time reset lets go
  always_ff @(posedge mclk_in) begin
    strap_sync1_reg <= clock_strap_pin_in;
    strap_sync2_reg <= strap_sync1_reg;
  end

  // source bit follows the strap for as long as reset is held
  // the value left at release is the strap seen two edges before
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      input_clock_source_bit_reg <= strap_sync2_reg;
    end else if (wr_input_mode) begin
      input_clock_source_bit_reg <= wr_data_in[`INPUT_SRC_BIT];
    end
  end

  // main clock source mux; reserved code gives a quiet pin
  // a steady low is safer for a consumer than a random clock
  assign main_selected_clk =
    (main_clk_out_source_reg == `MAIN_SRC_SYS1) ? sys_clock_1_in :
    (main_clk_out_source_reg == `MAIN_SRC_SYS2) ? sys_clock_2_in :
    (main_clk_out_source_reg == `MAIN_SRC_SYS3) ? sys_clock_3_in :
    1'b0;

  // disable forces a steady low rather than a stopped high
  assign main_clock_pin_out =
    main_clk_out_disable_reg ? 1'b0 : main_selected_clk;

  // aux pin: debug taps only on request, unsupported codes low
  // the taps are meant for bring-up, not for normal operation
  assign aux_selected_clk =
    (aux_clk_select_reg == `AUX_SEL_DIRECT)  ? direct_div_clk_in :
    (aux_clk_select_reg == `AUX_SEL_TAP_A)   ? pll_tap_a_in :
    (aux_clk_select_reg == `AUX_SEL_TAP_B)   ? pll_tap_b_in :
    (aux_clk_select_reg == `AUX_SEL_OSC_DIV) ? osc_div_clk_in :
    1'b0;
  assign aux_clock_pin_out = aux_selected_clk;

  // device input clock: oscillator on 0, external pin on 1
  // limitation: a plain mux; switching while both sources run
  // can give a short pulse, so change it only while quiet
  assign dev_input_clock_out =
    input_clock_source_bit_reg ? ext_clock_pin_in
                               : osc_output_in;

  // read-back words, reserved bits zero
  // words are rebuilt from fields, so reserved bits cannot leak
  assign wake_mask_word = {{(`DATA_W-`WAKE_W){1'b0}},
                           osc_wake_mask_reg};
  assign clock_route_word =
    {{(`DATA_W-`ROUTE_SRC_MSB-1){1'b0}},
     main_clk_out_source_reg, main_clk_out_disable_reg};
  assign input_mode_word =
    {{(`DATA_W-1){1'b0}}, input_clock_source_bit_reg};
  assign aux_route_word =
    {{(`DATA_W-`AUX_SEL_MSB-1){1'b0}}, aux_clk_select_reg};
  assign pll_status_word =
    {{(`DATA_W-`PLLCS_BUSY_BIT-1){1'b0}},
     wk.stab_busy, osc_sleep_flag_reg};

  // read select; unmapped addresses read zero
  // priority order is harmless: the address hits are exclusive
  assign read_mux =
    hit_wake_mask   ? wake_mask_word   :
    hit_clock_route ? clock_route_word :
    hit_input_mode  ? input_mode_word  :
    hit_aux_route   ? aux_route_word   :
    hit_pll_status  ? pll_status_word  :
    `WORD_ZERO;

  // read data valid only in the cycle after the strobe
  // zero outside that cycle keeps stale data off the bus and
  // makes a late sample by the master easy to spot
  assign rd_data_next = rd_en_in ? read_mux : `WORD_ZERO;

  // read data register
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rd_data_reg <= `WORD_ZERO;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // status outputs
  // straight from registers and the monitor state, no extra delay
  assign rd_data_out                = rd_data_reg;
  assign input_clock_source_bit_out = input_clock_source_bit_reg;
  assign osc_sleep_flag_out         = osc_sleep_flag_reg;
  assign stabilizing_out            = wk.stab_busy;
  assign cpu_resume_out             = wk.resume;
endmodule

/* sim/clock_out_and_wake_select_assertions.sv */
// port-level property checker for the clock output and wake select block
`timescale 1ns/1ps
`include "clk_sel_cfg.svh"
module clock_out_and_wake_select_checker #(
  parameter int STAB_CYCLES = `STAB_CYCLES_DEFAULT
) (
  input wire logic                   mclk_in,
  input wire logic                   sys_rst_in,
  input wire clk_sel_pkg::reg_addr_t addr_in,
  input wire logic                   wr_en_in,
  input wire logic                   rd_en_in,
  input wire clk_sel_pkg::reg_word_t rd_data_out,
  input wire logic                   clock_strap_pin_in,
  input wire logic                   osc_output_in,
  input wire logic                   ext_clock_pin_in,
  input wire logic                   dev_input_clock_out,
  input wire logic                   input_clock_source_bit_out,
  input wire logic                   osc_sleep_flag_out,
  input wire logic                   stabilizing_out,
  input wire logic                   cpu_resume_out
);
  import clk_sel_pkg::*;
  int stab_len;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  // length of the current stabilising run; a stuck count overruns
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !stabilizing_out) stab_len <= 0;
    else stab_len <= stab_len + 1;
  end

  dev_clk_mux_a: assert property (
    dev_input_clock_out == (input_clock_source_bit_out ?
                            ext_clock_pin_in : osc_output_in))
    else $error("input clock mux wrong");
  rd_idle_zero_a: assert property (
    !$past(rd_en_in) |-> rd_data_out == `WORD_ZERO)
    else $error("read data not zero outside read");
  mask_rsvd_a: assert property (
    $past(rd_en_in) && $past(addr_in) == `ADDR_OSC_WAKE_MASK
    |-> rd_data_out[15:5] == 11'h000)
    else $error("wake mask upper bits not zero");
  aux_rsvd_a: assert property (
    $past(rd_en_in) && $past(addr_in) == `ADDR_AUX_CLOCK_ROUTE
    |-> rd_data_out[15:4] == 12'h000)
    else $error("aux select upper bits not zero");
  strap_load_a: assert property (
    $fell(sys_rst_in)
    |-> input_clock_source_bit_out == $past(clock_strap_pin_in, 3))
    else $error("source bit not loaded from strap");
  stab_len_a: assert property (
    $fell(stabilizing_out) |-> stab_len == STAB_CYCLES)
    else $error("stabilising run wrong length");
  stab_max_a: assert property (
    stab_len <= STAB_CYCLES)
    else $error("stabilising run too long");
  resume_after_a: assert property (
    $fell(stabilizing_out) |-> cpu_resume_out)
    else $error("no resume after stabilising");
  wake_clears_a: assert property (
    $rose(stabilizing_out)
    |-> !osc_sleep_flag_out && $past(osc_sleep_flag_out, 2))
    else $error("wake without sleep or flag kept");
  flag_by_write_a: assert property (
    $rose(osc_sleep_flag_out)
    |-> $past(wr_en_in) && $past(addr_in) == `ADDR_PLL_CTRL_STATUS)
    else $error("sleep flag set without write");
  sleep_holds_a: assert property (
    osc_sleep_flag_out |-> !cpu_resume_out && !stabilizing_out)
    else $error("running while asleep");
endmodule

bind clock_out_and_wake_select clock_out_and_wake_select_checker #(
  .STAB_CYCLES(STAB_CYCLES)
) chk (
  .mclk_in(mclk_in),
  .sys_rst_in(sys_rst_in),
  .addr_in(addr_in),
  .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out),
  .clock_strap_pin_in(clock_strap_pin_in),
  .osc_output_in(osc_output_in),
  .ext_clock_pin_in(ext_clock_pin_in),
  .dev_input_clock_out(dev_input_clock_out),
  .input_clock_source_bit_out(input_clock_source_bit_out),
  .osc_sleep_flag_out(osc_sleep_flag_out),
  .stabilizing_out(stabilizing_out),
  .cpu_resume_out(cpu_resume_out)
);

/* sim/tb_clock_out_and_wake_select.sv */
// self-checking bench for the clock output and wake select block
`timescale 1ns/1ps
`include "clk_sel_cfg.svh"
module tb_clock_out_and_wake_select;
  import clk_sel_pkg::*;
  localparam int STAB = 8;
  localparam logic [3:0] AUX_CODE [4] = '{`AUX_SEL_TAP_A, `AUX_SEL_TAP_B,
                                          `AUX_SEL_OSC_DIV, `AUX_SEL_DIRECT};
  logic      mclk_in = 1'b0;
  logic      sys_rst_in = 1'b1;
  reg_addr_t addr_in = 16'h0000;
  reg_word_t wr_data_in = 16'h0000;
  logic      wr_en_in = 1'b0;
  logic      rd_en_in = 1'b0;
  logic      strap = 1'b1;
  logic      osc_out = 1'b0;
  logic      ext_clk = 1'b0;
  logic [4:0] wake_pins = 5'h00;
  logic [3:0] main_src = 4'h0;
  logic [3:0] aux_src = 4'h0;
  reg_word_t rd_data_out;
  logic      main_pin, aux_pin, dev_clk, src_bit, sleep_flag, stab, resume;
  int        err_count = 0;
  int        total_checks = 0;
  int        n;

  clock_out_and_wake_select #(.STAB_CYCLES(STAB)) uut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .nmi_in(wake_pins[0]),
    .ext_irq0_in(wake_pins[1]), .ext_irq1_in(wake_pins[2]),
    .ext_irq2_in(wake_pins[3]), .ext_irq3_in(wake_pins[4]),
    .clock_strap_pin_in(strap), .osc_output_in(osc_out),
    .ext_clock_pin_in(ext_clk), .sys_clock_1_in(main_src[1]),
    .sys_clock_2_in(main_src[2]), .sys_clock_3_in(main_src[3]),
    .pll_tap_a_in(aux_src[0]), .pll_tap_b_in(aux_src[1]),
    .osc_div_clk_in(aux_src[2]), .direct_div_clk_in(aux_src[3]),
    .main_clock_pin_out(main_pin), .aux_clock_pin_out(aux_pin),
    .dev_input_clock_out(dev_clk), .input_clock_source_bit_out(src_bit),
    .osc_sleep_flag_out(sleep_flag), .stabilizing_out(stab),
    .cpu_resume_out(resume));

  // 200 MHz reference clock
  always #2.5 mclk_in = ~mclk_in;

  // comparisons and verdict
  task automatic chk16(input string s, input reg_word_t e, input reg_word_t g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk1(input string s, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // bus cycles: one-cycle strobes, read data taken in the following cycle
  task automatic wr(input reg_addr_t a, input reg_word_t d);
    @(posedge mclk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge mclk_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rchk(input reg_addr_t a, input reg_word_t e);
    @(posedge mclk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge mclk_in);
    rd_en_in <= 1'b0;
    #1;
    chk16($sformatf("read %h", a), e, rd_data_out);
  endtask
  task automatic do_reset(input logic s);
    @(posedge mclk_in);
    strap <= s;
    sys_rst_in <= 1'b1;
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge mclk_in);
    if (v) wake_pins <= wake_pins | (5'h01 << i);
    else wake_pins <= wake_pins & ~(5'h01 << i);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge mclk_in);
    #1;
  endtask
  // bounded wait for a wake, then length of the stabilising run
  task automatic wait_wake(output int len);
    int k;
    k = 0;
    while (stab !== 1'b1 && k < 20) begin
      settle(1);
      k++;
    end
    len = 0;
    while (stab === 1'b1 && len < 100) begin
      settle(1);
      len++;
    end
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    end_of_test();
  end

  // main sequence
  initial begin
    do_reset(1'b1);
    rchk(`ADDR_OSC_WAKE_MASK, 16'h001f);
    rchk(`ADDR_CLOCK_OUT_ROUTE, 16'h0002);
    rchk(`ADDR_CLOCK_INPUT_MODE, 16'h0001);
    rchk(`ADDR_AUX_CLOCK_ROUTE, 16'h000b);
    rchk(`ADDR_PLL_CTRL_STATUS, 16'h0000);
    wr(`ADDR_OSC_WAKE_MASK, 16'hffff);
    rchk(`ADDR_OSC_WAKE_MASK, 16'h001f);
    wr(16'h0010, 16'hffff);
    rchk(16'h0010, 16'h0000);
    // main pin over every source code and disable level
    for (int c = 0; c < 8; c++) begin
      wr(`ADDR_CLOCK_OUT_ROUTE, 16'hfff8 | 16'(c));
      rchk(`ADDR_CLOCK_OUT_ROUTE, 16'(c));
      for (int k = 1; k < 4; k++) begin
        @(posedge mclk_in);
        main_src <= 4'(1 << k);
        settle(0);
        chk1("main pin", (c >> 1) == k && !c[0], main_pin);
      end
    end
    // aux pin over all sixteen codes, one source high at a time
    for (int c = 0; c < 16; c++) begin
      wr(`ADDR_AUX_CLOCK_ROUTE, 16'hfff0 | 16'(c));
      rchk(`ADDR_AUX_CLOCK_ROUTE, 16'(c));
      for (int k = 0; k < 4; k++) begin
        @(posedge mclk_in);
        aux_src <= 4'(1 << k);
        settle(0);
        chk1("aux pin", 4'(c) == AUX_CODE[k], aux_pin);
      end
    end
    // software puts the aux select back to the normal code
    wr(`ADDR_AUX_CLOCK_ROUTE, 16'(`AUX_SEL_DIRECT));
    @(posedge mclk_in);
    aux_src <= 4'h8;
    settle(0);
    chk1("aux pin normal", 1'b1, aux_pin);
    // input clock source both ways
    for (int c = 0; c < 2; c++) begin
      wr(`ADDR_CLOCK_INPUT_MODE, 16'hfffe | 16'(c));
      for (int k = 0; k < 4; k++) begin
        @(posedge mclk_in);
        osc_out <= k[0];
        ext_clk <= k[1];
        settle(0);
        chk1("input clock", c[0] ? k[1] : k[0], dev_clk);
      end
      chk1("source bit", c[0], src_bit);
      rchk(`ADDR_CLOCK_INPUT_MODE, 16'(c));
    end
    // all masked: no edge wakes the oscillator
    wr(`ADDR_PLL_CTRL_STATUS, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      pin(i, 1'b1);
      pin(i, 1'b0);
    end
    settle(6);
    chk1("sleep flag", 1'b1, sleep_flag);
    chk1("stabilising", 1'b0, stab);
    // one input unmasked; a level held high before sleep is no edge
    for (int i = 0; i < 5; i++) begin
      wr(`ADDR_PLL_CTRL_STATUS, 16'h0000);
      wr(`ADDR_OSC_WAKE_MASK, 16'h001f ^ 16'(1 << i));
      pin(i, 1'b1);
      wr(`ADDR_PLL_CTRL_STATUS, 16'h0001);
      pin((i + 1) % 5, 1'b1);
      pin((i + 1) % 5, 1'b0);
      settle(6);
      chk1("sleep flag", 1'b1, sleep_flag);
      pin(i, 1'b0);
      pin(i, 1'b1);
      wait_wake(n);
      chk16("stab cycles", 16'(STAB), 16'(n));
      chk1("sleep flag", 1'b0, sleep_flag);
      chk1("resume", 1'b1, resume);
      pin(i, 1'b0);
    end
    // unmasked edge while awake starts nothing
    wr(`ADDR_OSC_WAKE_MASK, 16'h0000);
    pin(2, 1'b1);
    settle(6);
    chk1("stabilising", 1'b0, stab);
    chk1("resume", 1'b1, resume);
    // second reset with the strap low
    do_reset(1'b0);
    settle(1);
    chk1("source bit", 1'b0, src_bit);
    rchk(`ADDR_CLOCK_INPUT_MODE, 16'h0000);
    rchk(`ADDR_OSC_WAKE_MASK, 16'h001f);
    end_of_test();
  end
endmodule
